//--- core/charger_detect_qualifier.sv
// Qualifies the charger comparator with line state and flags its changes.
// Assumes comparator and line state are synchronous to clk.
`default_nettype none
module charger_detect_qualifier
   import vbus_charger_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic chargerCompare,
   input wire logic [1:0] lineState,
   output logic detect,
   output logic changePulse
);
   logic gated;

   // Detect may assert only while the lines sit at SE0
   assign gated = chargerCompare && (lineState == LINE_SE0);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         detect <= 1'b0;
         changePulse <= 1'b0;
      end
      else if (ce)
      begin
         detect <= gated;
         changePulse <= gated ^ detect;
      end
      else
      begin
         changePulse <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_detect_gated: assert property (ce && lineState != LINE_SE0 |=> !detect)
      else $error("detect asserted outside SE0");
   a_change_pulse: assert property (ce && (gated != detect) |=> changePulse)
      else $error("detect change not reported");
   a_change_quiet: assert property (ce && (gated == detect) |=> !changePulse)
      else $error("event reported without a detect change");
   c_detect_seen: cover property (ce && gated ##1 detect);
endmodule
`default_nettype wire

//--- core/vbus_charger_control.sv
// VBUS pulsing, supply enable and charger-detect mode control.
// Assumes a byte register port on clk and synchronous analog inputs.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`default_nettype none
module vbus_charger_control
   import vbus_charger_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [vbus_charger_pkg::ADDR_W-1:0] regAddr,
   input wire logic [vbus_charger_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [vbus_charger_pkg::DATA_W-1:0] regRdata,
   input wire logic [1:0] lineState,
   input wire logic chargerCompare,
   input wire logic vbusCompare,
   input wire logic uartMode,
   input wire logic lowPowerMode,
   output logic vbusDischargeEnable,
   output logic vbusChargeEnable,
   output logic supplySwitchEnable,
   output logic voltageSourceEnable,
   output logic currentSinkEnable,
   output logic contactDetectEnable,
   output logic hostChargerEnable,
   output logic fifthControlEnable,
   output logic minusLinePulldown,
   output logic chargerVoltageDetect,
   output logic chargerEvent,
   output logic vbusValid,
   output logic [1:0] lineStateOut,
   output logic [vbus_charger_pkg::LEVEL_W-1:0] regulatorLevel
);
   import vbus_charger_pkg::*;

   function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      return strobe && (a == off);
   endfunction

   logic [DATA_W-1:0] otgCtrl;
   logic [DATA_W-1:0] indCtrl;
   logic [CHG_W-1:0] chgCtrl;
   logic [3:0] pwrCtrl;
   logic eventFlag;
   logic uartPrev;
   logic wrOtg;
   logic wrInd;
   logic wrChg;
   logic wrPwr;
   logic wrStat;
   logic rdAny;
   logic uartEntry;
   logic [LEVEL_W-1:0] uartLevelField;
   logic [LEVEL_W-1:0] normalLevelField;
   logic [LEVEL_W-1:0] next_regulatorLevel;
   logic next_vbusValid;
   logic [DATA_W-1:0] statusWord;
   logic [DATA_W-1:0] readValue;

   // Register decode
   assign wrOtg = ce && hit(regWrite, regAddr, REG_OTG);
   assign wrInd = ce && hit(regWrite, regAddr, REG_IND);
   assign wrChg = ce && hit(regWrite, regAddr, REG_CHG);
   assign wrPwr = ce && hit(regWrite, regAddr, REG_PWR);
   assign wrStat = ce && hit(regWrite, regAddr, REG_STAT);
   assign rdAny = regRead && ce;

   // Analog enables straight from the control flops
   assign vbusDischargeEnable = otgCtrl[OTG_DISCHARGE_BIT];
   assign vbusChargeEnable = otgCtrl[OTG_CHARGE_BIT];
   // Either drive bit turns on the external supply switch
   assign supplySwitchEnable = otgCtrl[OTG_DRIVE_INT_BIT] | otgCtrl[OTG_DRIVE_EXT_BIT];
   assign voltageSourceEnable = chgCtrl[CHG_SRC_BIT];
   assign currentSinkEnable = chgCtrl[CHG_SINK_BIT];
   assign contactDetectEnable = chgCtrl[CHG_CONTACT_BIT];
   assign hostChargerEnable = chgCtrl[CHG_HOST_BIT];
   assign fifthControlEnable = chgCtrl[CHG_FIFTH_BIT];
   assign minusLinePulldown = chgCtrl[CHG_PULLDOWN_BIT];

   // Vbus valid source selection
   assign next_vbusValid = !otgCtrl[OTG_EXT_SEL_BIT] ? vbusCompare :
                           indCtrl[IND_COMP_BIT] ? 1'b0 :
                           indCtrl[IND_PASS_BIT] ? 1'b1 : vbusCompare;

   // Regulator level selection around UART mode
   assign uartLevelField = pwrCtrl[PWR_UART_LSB +: LEVEL_W];
   assign normalLevelField = pwrCtrl[PWR_NORM_LSB +: LEVEL_W];
   assign uartEntry = uartMode && !uartPrev;
   assign next_regulatorLevel = uartEntry ? uartLevelField :
                                uartMode ? regulatorLevel : normalLevelField;

   // Read path
   assign statusWord = {1'b0, eventFlag, lowPowerMode, uartMode,
                        lineStateOut, vbusValid, chargerVoltageDetect};
   assign readValue = (regAddr == REG_OTG) ? otgCtrl :
                      (regAddr == REG_IND) ? indCtrl :
                      (regAddr == REG_CHG) ? {2'h0, chgCtrl} :
                      (regAddr == REG_PWR) ? {4'h0, pwrCtrl} :
                      (regAddr == REG_STAT) ? statusWord : 8'h00;

   // Charger detection is not gated by low power mode
   charger_detect_qualifier u_qualifier (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .chargerCompare(chargerCompare),
      .lineState(lineState),
      .detect(chargerVoltageDetect),
      .changePulse(chargerEvent)
   );

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         otgCtrl <= OTG_RST;
      else if (wrOtg)
         otgCtrl <= regWdata;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         indCtrl <= IND_RST;
      else if (wrInd)
         indCtrl <= regWdata;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         chgCtrl <= CHG_RST;
      else if (wrChg)
         chgCtrl <= regWdata[CHG_W-1:0];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pwrCtrl <= PWR_RST;
      else if (wrPwr)
         pwrCtrl <= regWdata[3:0];
   end

   // Event flag: a new event wins over a write-one clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         eventFlag <= 1'b0;
      else if (ce && chargerEvent)
         eventFlag <= 1'b1;
      else if (wrStat && regWdata[STAT_EVENT_BIT])
         eventFlag <= 1'b0;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         uartPrev <= 1'b0;
         regulatorLevel <= PWR_RST[PWR_NORM_LSB +: LEVEL_W];
         vbusValid <= 1'b0;
         lineStateOut <= LINE_SE0;
      end
      else if (ce)
      begin
         uartPrev <= uartMode;
         regulatorLevel <= next_regulatorLevel;
         vbusValid <= next_vbusValid;
         lineStateOut <= uartMode ? LINE_SE0 : lineState;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         regRdata <= 8'h00;
      else if (rdAny)
         regRdata <= readValue;
   end

   // Helper state for the checks below
   logic otgWritten;
   logic chgWritten;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         otgWritten <= 1'b0;
         chgWritten <= 1'b0;
      end
      else
      begin
         otgWritten <= otgWritten | wrOtg;
         chgWritten <= chgWritten | wrChg;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Register write and enable checks
   a_discharge_write: assert property (wrOtg |=>
      vbusDischargeEnable == $past(regWdata[3]))
      else $error("discharge enable does not follow write");
   a_charge_write: assert property (wrOtg |=>
      vbusChargeEnable == $past(regWdata[4]))
      else $error("charge enable does not follow write");
   a_supply_or: assert property (wrOtg |=>
      supplySwitchEnable == ($past(regWdata[5]) | $past(regWdata[6])))
      else $error("supply enable is not OR of drive bits");
   a_supply_reset: assert property (!otgWritten |-> !supplySwitchEnable)
      else $error("supply enable set before any write");
   a_uart_entry: assert property (ce && uartMode && !uartPrev |=>
      regulatorLevel == $past(uartLevelField))
      else $error("regulator not switched on UART entry");
   a_uart_line: assert property (ce && uartMode |=> lineStateOut == 2'h0)
      else $error("line state shown during UART mode");
   a_lowpower_detect: assert property (ce && lowPowerMode && chargerCompare &&
      lineState == 2'h0 |=> chargerVoltageDetect)
      else $error("charger detect lost in low power");
   a_event_sticky: assert property (ce && chargerEvent |=> eventFlag)
      else $error("charger event not held in status");
   a_vbus_fixed: assert property (ce && otgCtrl[7] && indCtrl[6] && !indCtrl[5] |=>
      vbusValid)
      else $error("fixed vbus valid one not applied");
   a_mode_write: assert property (wrChg |=>
      {minusLinePulldown, fifthControlEnable, hostChargerEnable, contactDetectEnable,
       currentSinkEnable, voltageSourceEnable} == $past(regWdata[5:0]))
      else $error("mode enables not updated after write");
   a_mode_reset: assert property (!chgWritten |-> chgCtrl == 6'h00)
      else $error("charger mode bits set before any write");
   a_read_unmapped: assert property (rdAny && regAddr > 8'h04 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");

   // Hold, freeze and read-back checks
   a_otg_hold: assert property (!wrOtg |=> $stable(otgCtrl))
      else $error("OTG control changed without a write");
   a_mode_hold: assert property (!wrChg |=> $stable(chgCtrl))
      else $error("charger mode changed without a write");
   a_vbus_comp: assert property (ce && !otgCtrl[OTG_EXT_SEL_BIT] |=>
      vbusValid == $past(vbusCompare))
      else $error("vbus valid not taken from comparator");
   a_vbus_zero: assert property (ce && otgCtrl[OTG_EXT_SEL_BIT] &&
      indCtrl[IND_COMP_BIT] |=> !vbusValid)
      else $error("fixed vbus valid zero not applied");
   a_line_pass: assert property (ce && !uartMode |=>
      lineStateOut == $past(lineState))
      else $error("line state not passed outside UART mode");
   a_uart_hold: assert property (ce && uartMode && uartPrev |=>
      $stable(regulatorLevel))
      else $error("regulator level moved during UART mode");
   a_level_normal: assert property (ce && !uartMode |=>
      regulatorLevel == $past(normalLevelField))
      else $error("regulator level not normal outside UART mode");
   a_detect_line: assert property (ce && lineState != LINE_SE0 |=>
      !chargerVoltageDetect)
      else $error("charger detect asserted outside SE0");
   a_event_hold: assert property (eventFlag && !(wrStat && regWdata[STAT_EVENT_BIT]) |=>
      eventFlag)
      else $error("event status lost without a clear");
   a_event_clear: assert property (wrStat && regWdata[STAT_EVENT_BIT] && !chargerEvent |=>
      !eventFlag)
      else $error("event status not cleared by write");
   a_freeze_state: assert property (!ce |=> $stable(vbusValid) && $stable(lineStateOut) &&
      $stable(regulatorLevel) && !chargerEvent)
      else $error("state moved while clock enable low");
   a_read_hold: assert property (!rdAny |=> $stable(regRdata))
      else $error("read data changed without a read");
   a_read_otg: assert property (rdAny && regAddr == REG_OTG |=>
      regRdata == $past(otgCtrl))
      else $error("OTG control read back wrong");
   a_read_chg: assert property (rdAny && regAddr == REG_CHG |=>
      regRdata == {2'h0, $past(chgCtrl)})
      else $error("charger mode read back wrong");
   a_read_pwr: assert property (rdAny && regAddr == REG_PWR |=>
      regRdata == {4'h0, $past(pwrCtrl)})
      else $error("power control read back wrong");
   a_read_event: assert property (rdAny && regAddr == REG_STAT |=>
      regRdata[STAT_EVENT_BIT] == $past(eventFlag))
      else $error("event status read back wrong");

   c_supply_on: cover property (wrOtg ##1 supplySwitchEnable);
   c_uart_entry: cover property (ce && uartEntry);
   c_event_clear: cover property (eventFlag ##1 !eventFlag);
   c_host_port: cover property (wrChg ##1 hostChargerEnable && minusLinePulldown);
endmodule
`default_nettype wire

//--- core/vbus_charger_pkg.sv
// Constants for the VBUS and charger-detect control block.
// Assumes one 60 MHz ULPI-side clock and a byte-wide register port.
`default_nettype none
package vbus_charger_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] REG_OTG = 8'h00;
   localparam logic [7:0] REG_IND = 8'h01;
   localparam logic [7:0] REG_CHG = 8'h02;
   localparam logic [7:0] REG_PWR = 8'h03;
   localparam logic [7:0] REG_STAT = 8'h04;
   // OTG control fields
   localparam int OTG_DISCHARGE_BIT = 3;
   localparam int OTG_CHARGE_BIT = 4;
   localparam int OTG_DRIVE_INT_BIT = 5;
   localparam int OTG_DRIVE_EXT_BIT = 6;
   localparam int OTG_EXT_SEL_BIT = 7;
   // External indicator fields
   localparam int IND_COMP_BIT = 5;
   localparam int IND_PASS_BIT = 6;
   // Charger-detect mode fields
   localparam int CHG_SRC_BIT = 0;
   localparam int CHG_SINK_BIT = 1;
   localparam int CHG_CONTACT_BIT = 2;
   localparam int CHG_HOST_BIT = 3;
   localparam int CHG_FIFTH_BIT = 4;
   localparam int CHG_PULLDOWN_BIT = 5;
   localparam int CHG_W = 6;
   // Power management fields
   localparam int PWR_UART_LSB = 0;
   localparam int PWR_NORM_LSB = 2;
   localparam int LEVEL_W = 2;
   // Status fields
   localparam int STAT_EVENT_BIT = 6;
   // Reset values
   localparam logic [7:0] OTG_RST = 8'h00;
   localparam logic [7:0] IND_RST = 8'h00;
   localparam logic [5:0] CHG_RST = 6'h00;
   localparam logic [3:0] PWR_RST = 4'h0;
   localparam logic [1:0] LINE_SE0 = 2'h0;
endpackage
`default_nettype wire

//--- test/link_model.sv
// Link-side model that masters the byte register port.
// Assumes the block samples strobes on the rising edge of clk.
`default_nettype none
module link_model
   import vbus_charger_pkg::*;
(
   input wire logic clk,
   output logic [vbus_charger_pkg::ADDR_W-1:0] regAddr,
   output logic [vbus_charger_pkg::DATA_W-1:0] regWdata,
   output logic regWrite,
   output logic regRead,
   input wire logic [vbus_charger_pkg::DATA_W-1:0] regRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // One-cycle write strobe, data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regWdata <= ~d;
      #1;
   endtask
   // One-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdata;
   endtask
endmodule
`default_nettype wire

//--- test/vbus_and_charger_detect_control_tb.sv
// Self-checking bench for the VBUS and charger-detect control block.
// Assumes link_model masters the register port; ce is held high except while t_hold drives it low.
`default_nettype none
module vbus_and_charger_detect_control_tb;
   import vbus_charger_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, ce, regWrite, regRead, chargerCompare, vbusCompare, uartMode, lowPowerMode;
   logic [7:0] regAddr, regWdata, regRdata;
   logic [1:0] lineState, lineStateOut, regulatorLevel;
   logic vbusDischargeEnable, vbusChargeEnable, supplySwitchEnable, voltageSourceEnable;
   logic currentSinkEnable, contactDetectEnable, hostChargerEnable, fifthControlEnable;
   logic minusLinePulldown, chargerVoltageDetect, chargerEvent, vbusValid;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   wire [7:0] otgOut = {5'h0, vbusDischargeEnable, vbusChargeEnable, supplySwitchEnable};
   wire [7:0] chgOut = {2'h0, minusLinePulldown, fifthControlEnable, hostChargerEnable,
      contactDetectEnable, currentSinkEnable, voltageSourceEnable};
   vbus_charger_control u_vbus_charger_control (.clk(clk), .rstn(rstn), .ce(ce),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .lineState(lineState), .chargerCompare(chargerCompare),
      .vbusCompare(vbusCompare), .uartMode(uartMode), .lowPowerMode(lowPowerMode),
      .vbusDischargeEnable(vbusDischargeEnable), .vbusChargeEnable(vbusChargeEnable),
      .supplySwitchEnable(supplySwitchEnable), .voltageSourceEnable(voltageSourceEnable),
      .currentSinkEnable(currentSinkEnable), .contactDetectEnable(contactDetectEnable),
      .hostChargerEnable(hostChargerEnable), .fifthControlEnable(fifthControlEnable),
      .minusLinePulldown(minusLinePulldown), .chargerVoltageDetect(chargerVoltageDetect),
      .chargerEvent(chargerEvent), .vbusValid(vbusValid), .lineStateOut(lineStateOut),
      .regulatorLevel(regulatorLevel));
   link_model u_link_model (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
   always #25 clk = ~clk;
   task automatic summarize();
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic t_otg();
      logic [7:0] v [6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'h00};
      logic [7:0] e [6] = '{8'h04, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00};
      for (int i = 0; i < 6; i++)
      begin
         u_link_model.wr(REG_OTG, v[i]);
         chk(otgOut, e[i]);
      end
   endtask
   task automatic t_chg();
      logic [7:0] m [7] = '{8'h24, 8'h03, 8'h0b, 8'h3a, 8'h3b, 8'h38, 8'h00};
      logic [7:0] d;
      for (int i = 0; i < 7; i++)
      begin
         u_link_model.wr(REG_CHG, m[i]);
         chk(chgOut, m[i]);
         u_link_model.rd(REG_CHG, d);
         chk(d, m[i]);
      end
   endtask
   task automatic t_detect();
      logic [7:0] d;
      @(posedge clk);
      lowPowerMode <= 1'b1;
      chargerCompare <= 1'b1;
      lineState <= 2'h1;
      repeat (2) @(posedge clk);
      #1 chk({7'h0, chargerVoltageDetect}, 8'h00);
      @(posedge clk);
      lineState <= LINE_SE0;
      @(posedge clk);
      #1 chk({6'h0, chargerVoltageDetect, chargerEvent}, 8'h03);
      @(posedge clk);
      #1 chk({7'h0, chargerEvent}, 8'h00);
      u_link_model.rd(REG_STAT, d);
      chk(d & 8'h7d, 8'h61);
      u_link_model.wr(REG_STAT, 8'h40);
      u_link_model.rd(REG_STAT, d);
      chk(d & 8'h40, 8'h00);
      u_link_model.rd(8'h7f, d);
      chk(d, 8'h00);
   endtask
   task automatic t_uart();
      u_link_model.wr(REG_PWR, 8'h06);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, regulatorLevel}, 8'h01);
      @(posedge clk);
      uartMode <= 1'b1;
      lineState <= 2'h3;
      repeat (2) @(posedge clk);
      #1 chk({4'h0, regulatorLevel, lineStateOut}, 8'h08);
      u_link_model.wr(REG_PWR, 8'h0d);
      @(posedge clk);
      #1 chk({6'h0, regulatorLevel}, 8'h02);
      @(posedge clk);
      uartMode <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({4'h0, regulatorLevel, lineStateOut}, 8'h0f);
   endtask
   task automatic t_ind();
      logic [17:0] r [6] = '{{8'h00, 8'h60, 2'b11}, {8'h80, 8'h40, 2'b01},
         {8'h80, 8'h60, 2'b10}, {8'h80, 8'h00, 2'b00}, {8'h80, 8'h00, 2'b11},
         {8'h80, 8'h20, 2'b10}};
      for (int i = 0; i < 6; i++)
      begin
         u_link_model.wr(REG_OTG, r[i][17:10]);
         u_link_model.wr(REG_IND, r[i][9:2]);
         @(posedge clk);
         vbusCompare <= r[i][1];
         repeat (2) @(posedge clk);
         #1 chk({7'h0, vbusValid}, {7'h0, r[i][0]});
      end
   endtask
   task automatic t_hold();
      logic [7:0] d;
      u_link_model.wr(REG_OTG, 8'h78);
      u_link_model.wr(REG_CHG, 8'h3f);
      @(posedge clk);
      ce <= 1'b0;
      lineState <= 2'h1;
      u_link_model.wr(REG_OTG, 8'h00);
      #1 chk(otgOut, 8'h07);
      chk({6'h0, lineStateOut}, 8'h03);
      @(posedge clk);
      ce <= 1'b1;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(otgOut, 8'h00);
      chk(chgOut, 8'h00);
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      u_link_model.rd(REG_OTG, d);
      chk(d, 8'h00);
      u_link_model.rd(REG_CHG, d);
      chk(d, 8'h00);
   endtask
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      ce = 1'b1;
      lineState = 2'h1;
      chargerCompare = 1'b0;
      vbusCompare = 1'b0;
      uartMode = 1'b0;
      lowPowerMode = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1 chk(otgOut, 8'h00);
      chk(chgOut, 8'h00);
      t_otg();
      t_chg();
      t_detect();
      t_uart();
      t_ind();
      t_hold();
      summarize();
   end
endmodule
`default_nettype wire
